// *** bench/sarc_conv_ctrl_asserts.sv ***
/* Port checker of sarc_conv_ctrl: switch order, timing, code hold, flag.
 Assumes binding onto the top with the same DIV value. */
`timescale 1ns/1ps
module sarc_conv_ctrl_asserts
	import sarc_pkg::*;
#(
	parameter int DIV = CONV_DIV
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic conversion_start_in,
	input wire logic clamp_pos_in,
	input wire logic clamp_neg_in,
	input wire logic spi_cs_n,
	input wire logic comp_ground_switch_pos,
	input wire logic comp_ground_switch_neg,
	input wire logic cap_to_input,
	input wire logic [CODE_W-1:0] dac_pos_ref,
	input wire logic [CODE_W-1:0] dac_neg_ref,
	input wire logic busy,
	input wire logic conv_done,
	input wire logic [CODE_W-1:0] result_code,
	input wire logic overvoltage_flag_n,
	input wire logic spi_sdo
);
	localparam int LO = 16 * DIV;
	localparam int HI = 20 * DIV + 10;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_gnd_open;
		!comp_ground_switch_pos && !comp_ground_switch_neg;
	endsequence
	sequence s_acq;
		comp_ground_switch_pos && comp_ground_switch_neg && cap_to_input;
	endsequence
	property p_busy_open;
		busy |-> s_gnd_open;
	endproperty
	a_busy_open: assert property (p_busy_open) else $error("ground closed in conversion");
	property p_order;
		$fell(cap_to_input) |-> s_gnd_open ##0 !$past(comp_ground_switch_pos);
	endproperty
	a_order: assert property (p_order) else $error("arrays moved before ground opened");
	property p_back;
		$fell(busy) |-> ##[0:3] s_acq;
	endproperty
	a_back: assert property (p_back) else $error("no return to acquisition");
	property p_start;
		$rose(conversion_start_in) && !busy && !conv_done |-> ##3 busy;
	endproperty
	a_start: assert property (p_start) else $error("start edge not taken");
	property p_len;
		$rose(busy) |-> ##[LO:HI] conv_done;
	endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");
	property p_done;
		conv_done |-> !busy && $past(busy) && !$past(conv_done);
	endproperty
	a_done: assert property (p_done) else $error("done without busy end");
	property p_hold;
		!conv_done |-> $stable(result_code);
	endproperty
	a_hold: assert property (p_hold) else $error("code changed between results");
	property p_msb;
		$rose(|dac_pos_ref) |-> dac_pos_ref == 16'h8000;
	endproperty
	a_msb: assert property (p_msb) else $error("search not msb first");
	property p_arrays;
		conv_done |-> (dac_pos_ref ^ dac_neg_ref) == 16'hffff &&
			dac_pos_ref == {~result_code[15], result_code[14:0]};
	endproperty
	a_arrays: assert property (p_arrays) else $error("arrays disagree with code");
	property p_ov_set;
		clamp_pos_in || clamp_neg_in |-> ##[1:4] !overvoltage_flag_n;
	endproperty
	a_ov_set: assert property (p_ov_set) else $error("clamp did not set flag");
	property p_ov_clr;
		$rose(overvoltage_flag_n) |-> spi_cs_n && !clamp_pos_in && !clamp_neg_in;
	endproperty
	a_ov_clr: assert property (p_ov_clr) else $error("flag cleared wrongly");
	property p_sdo_idle;
		spi_cs_n && $past(spi_cs_n, 5) |-> !spi_sdo;
	endproperty
	a_sdo_idle: assert property (p_sdo_idle) else $error("serial out busy idle");
endmodule : sarc_conv_ctrl_asserts
bind sarc_conv_ctrl sarc_conv_ctrl_asserts #(.DIV(DIV)) sarc_conv_ctrl_asserts_inst (.*);

// *** bench/sarc_host_model.sv ***
/* Host serial reader of result and config frames.
 Assumes the caller waits for each frame; link clock unrelated to core. */
`timescale 1ns/1ps
module sarc_host_model (
	input wire logic spi_sdo,
	output logic spi_cs_n,
	output logic spi_sck,
	output logic reg_read_sel
);
	initial begin
		spi_cs_n = 1'b1;
		spi_sck = 1'b0;
		reg_read_sel = 1'b0;
	end
	// Clock stands still outside frames; select held past frame end
	task automatic read_frame(input logic sel, output logic [17:0] w);
		reg_read_sel = sel;
		#40 spi_cs_n = 1'b0;
		#100;
		for (int i = 17; i >= 0; i--) begin
			spi_sck = 1'b1;
			w[i] = spi_sdo;
			#62.5 spi_sck = 1'b0;
			#62.5;
		end
		spi_cs_n = 1'b1;
		#100 reg_read_sel = 1'b0;
	endtask : read_frame
endmodule : sarc_host_model

// *** bench/tb_top.sv ***
/* Self-checking bench of sarc_conv_ctrl with a behavioural comparator.
 Assumes DIV slowed so the synced comparator settles within a tick. */
`timescale 1ns/1ps
module tb_top;
	import sarc_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, conversion_start_in = 1'b0, comparator_in = 1'b0;
	logic clamp_pos_in = 1'b0, clamp_neg_in = 1'b0, span_comp_en = 1'b0;
	logic spi_cs_n, spi_sck, reg_read_sel, comp_ground_switch_pos, comp_ground_switch_neg;
	logic cap_to_input, ref_span_compress, busy, conv_done, overvoltage_flag_n, spi_sdo;
	logic [CODE_W-1:0] dac_pos_ref, dac_neg_ref, result_code;
	logic [17:0] rx;
	int mismatches = 0, comparisons = 0, cyc = 0, ana = 0, a;
	int corner[8] = '{0, 1, -1, 32767, 40000, -32767, -32768, -50000};
	int unsigned seed_r;
	sarc_conv_ctrl #(.DIV(8)) sarc_conv_ctrl_inst (.*);
	sarc_host_model sarc_host_model_inst (.*);
	////////////////////////////////////////////////////////////
	always #5 core_clk = ~core_clk;
	// Ideal comparator: keep trial while it is not above the input
	always @(negedge core_clk) comparator_in <= int'(dac_pos_ref) <= tgt(ana);
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			summarize();
		end
	end
	function automatic int tgt(int v);
		return v > 32767 ? 65535 : v < -32768 ? 0 : v + 32768;
	endfunction : tgt
	function automatic logic [15:0] exp_code(int v);
		return 16'(tgt(v)) ^ 16'h8000;
	endfunction : exp_code
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Second start edge while busy must be dropped
	task automatic conv(input int v, input logic sp);
		repeat (6) @(negedge core_clk);
		ana = v;
		span_comp_en = sp;
		conversion_start_in = 1'b1;
		for (int n = 0; n < 20 && busy !== 1'b1; n++) @(negedge core_clk);
		chk({busy, cap_to_input}, 2'b11);
		repeat (10) @(negedge core_clk);
		conversion_start_in = 1'b0;
		span_comp_en = ~sp;
		repeat (3) @(negedge core_clk);
		conversion_start_in = 1'b1;
		for (int n = 0; n < 400 && conv_done !== 1'b1; n++) @(negedge core_clk);
		chk({conv_done, result_code}, {1'b1, exp_code(v)});
		chk(ref_span_compress, sp);
		conversion_start_in = 1'b0;
	endtask : conv
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////
	initial begin
		seed_r = $urandom(32'h30f2);
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		chk(overvoltage_flag_n, OV_FLAG_RESET);
		foreach (corner[i]) begin
			conv(corner[i], i[0]);
			sarc_host_model_inst.read_frame(1'b0, rx);
			chk(rx, {exp_code(corner[i]), 1'b1, i[0]});
		end
		repeat (8) begin
			a = int'($urandom_range(70000)) - 35000;
			conv(a, 1'($urandom_range(1)));
		end
		clamp_pos_in = 1'b1;
		repeat (6) @(negedge core_clk);
		clamp_pos_in = 1'b0;
		repeat (4) @(negedge core_clk);
		chk(overvoltage_flag_n, 1'b0);
		sarc_host_model_inst.read_frame(1'b0, rx);
		chk({rx[1], overvoltage_flag_n}, 2'b00);
		clamp_neg_in = 1'b1;
		sarc_host_model_inst.read_frame(1'b1, rx);
		repeat (6) @(negedge core_clk);
		chk({rx[6], overvoltage_flag_n}, 2'b00);
		clamp_neg_in = 1'b0;
		repeat (6) @(negedge core_clk);
		sarc_host_model_inst.read_frame(1'b1, rx);
		repeat (6) @(negedge core_clk);
		chk({rx, overvoltage_flag_n}, {11'h000, 1'b0, span_comp_en, 5'h00, 1'b1});
		sarc_host_model_inst.read_frame(1'b1, rx);
		chk(rx, {11'h000, 1'b1, span_comp_en, 5'h00});
		summarize();
	end
endmodule : tb_top

// *** verilog/sarc_conv_ctrl.sv ***
/*
 * Top of the SAR conversion control: switch sequencing, search, output code,
 * overvoltage flag and a small serial readout of code, status and config.
 * Assumes pins and the analog comparator/clamp detectors are asynchronous
 * and are synchronised here; span_comp_en comes from logic on core_clk.
 */
// Overview of operation
// - Acquisition: ground switches closed, all capacitors tied to the inputs.
// - Rising conversion start edge ends acquisition and begins conversion.
// - Open ground switches first, then move arrays from inputs to ground.
// - Sixteen step binary search, most significant bit first.
// - At search end present the code and drop busy.
// - Conversion timed by internal divider, never by the serial clock.
// - Code is two's complement; midscale reads zero.
// - Over range input saturates to the largest positive code.
// - Under range input saturates to the most negative code.
// - Span compression scales range to four fifths of the reference.
// - Clamp activity on either input sets the overvoltage flag.
// - Flag reads zero when overvoltage seen, one otherwise.
// - Flag readable in the register read and in the status bits.
// - Flag is sticky; cleared only by a register read without overvoltage.
`timescale 1ns/1ps
module sarc_conv_ctrl
	import sarc_pkg::*;
#(
	parameter int DIV = CONV_DIV
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic conversion_start_in,
	input wire logic comparator_in,
	input wire logic clamp_pos_in,
	input wire logic clamp_neg_in,
	input wire logic span_comp_en,
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic reg_read_sel,
	output logic comp_ground_switch_pos,
	output logic comp_ground_switch_neg,
	output logic cap_to_input,
	output logic [CODE_W-1:0] dac_pos_ref,
	output logic [CODE_W-1:0] dac_neg_ref,
	output logic ref_span_compress,
	output logic busy,
	output logic conv_done,
	output logic [CODE_W-1:0] result_code,
	output logic overvoltage_flag_n,
	output logic spi_sdo
);

	if (DIV < 4 || DIV > 255) begin : g_div_check
		$error("DIV must lie between 4 and 255, sync plus settle needs four cycles");
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [SYNC_IN_W-1:0] async_in;
	logic [SYNC_IN_W-1:0] meta_r;
	logic [SYNC_IN_W-1:0] sync_r;
	logic [SYNC_IN_W-1:0] sync_d_r;

	assign async_in = {reg_read_sel, spi_sck, spi_cs_n, clamp_neg_in, clamp_pos_in,
		comparator_in, conversion_start_in};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_IN_W; gi++) begin : g_sync
			// First stage feeds only the second stage
			always_ff @(posedge core_clk) begin
				if (rst) begin
					meta_r[gi] <= 1'(gi == SI_CS_N);
					sync_r[gi] <= 1'(gi == SI_CS_N);
					sync_d_r[gi] <= 1'(gi == SI_CS_N);
				end else begin
					meta_r[gi] <= async_in[gi];
					sync_r[gi] <= meta_r[gi];
					sync_d_r[gi] <= sync_r[gi];
				end
			end
		end
	endgenerate

	logic cnv_rise;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic clamp_now;

	assign cnv_rise = sync_r[SI_CNV] & ~sync_d_r[SI_CNV];
	assign cs_fall = ~sync_r[SI_CS_N] & sync_d_r[SI_CS_N];
	assign cs_rise = sync_r[SI_CS_N] & ~sync_d_r[SI_CS_N];
	assign sck_rise = sync_r[SI_SCK] & ~sync_d_r[SI_SCK];
	assign sck_fall = ~sync_r[SI_SCK] & sync_d_r[SI_SCK];
	assign clamp_now = sync_r[SI_CLAMP_P] | sync_r[SI_CLAMP_N];

	////////////////////////////////////////////////////////////////////////
	// Internal conversion clock enable

	logic [7:0] div_r;
	logic tick_r;

	// Free running so the conversion never waits on the serial clock
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_r <= 8'h00;
			tick_r <= 1'h0;
		end else if (div_r == 8'(DIV - 1)) begin
			div_r <= 8'h00;
			tick_r <= 1'h1;
		end else begin
			div_r <= div_r + 8'h01;
			tick_r <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer

	sarc_state_e state_r;
	sarc_state_e state_nxt;
	logic sar_load;
	logic sar_step;
	logic search_end;
	logic [CODE_W-1:0] trial;
	logic [CODE_W-1:0] active;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_ACQ: begin
				if (cnv_rise) begin
					state_nxt = ST_OPEN_GND;
				end
			end
			ST_OPEN_GND: begin
				if (tick_r) begin
					state_nxt = ST_TO_GND;
				end
			end
			ST_TO_GND: begin
				if (tick_r) begin
					state_nxt = ST_SEARCH;
				end
			end
			ST_SEARCH: begin
				if (search_end) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt = ST_ACQ;
			end
			default: begin
				state_nxt = ST_ACQ;
			end
		endcase
	end

	// Edges outside acquisition fall through unused
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= ST_ACQ;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sar_load = (state_r == ST_TO_GND) && tick_r;
	// Comparator has a full tick to settle, longer than the sync delay
	assign sar_step = (state_r == ST_SEARCH) && tick_r && !search_end;

	sarc_sar_core #(
		.W(CODE_W)
	) u_sar (
		.core_clk(core_clk),
		.rst(rst),
		.load(sar_load),
		.step(sar_step),
		.keep(sync_r[SI_COMP]),
		.trial_r(trial),
		.active_r(active),
		.search_end_r(search_end)
	);

	////////////////////////////////////////////////////////////////////////
	// Switch drive

	sarc_switch_s sw_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sw_r <= '{gnd_pos: 1'h1, gnd_neg: 1'h1, to_input: 1'h1, span_sel: 1'h0};
		end else begin
			unique case (state_nxt)
				ST_ACQ: begin
					sw_r.gnd_pos <= 1'h1;
					sw_r.gnd_neg <= 1'h1;
					sw_r.to_input <= 1'h1;
				end
				ST_OPEN_GND: begin
					sw_r.gnd_pos <= 1'h0;
					sw_r.gnd_neg <= 1'h0;
					sw_r.to_input <= 1'h1;
				end
				ST_TO_GND, ST_SEARCH, ST_DONE: begin
					sw_r.gnd_pos <= 1'h0;
					sw_r.gnd_neg <= 1'h0;
					sw_r.to_input <= 1'h0;
				end
				default: begin
					sw_r.gnd_pos <= 1'h1;
					sw_r.gnd_neg <= 1'h1;
					sw_r.to_input <= 1'h1;
				end
			endcase
			// Span choice frozen for the whole conversion
			if (state_r == ST_ACQ && cnv_rise) begin
				sw_r.span_sel <= span_comp_en;
			end
		end
	end

	assign comp_ground_switch_pos = sw_r.gnd_pos;
	assign comp_ground_switch_neg = sw_r.gnd_neg;
	assign cap_to_input = sw_r.to_input;
	assign ref_span_compress = sw_r.span_sel;

	// Arrays stay grounded until the search loads them
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dac_pos_ref <= '0;
			dac_neg_ref <= '0;
		end else if (state_r == ST_SEARCH || state_r == ST_DONE) begin
			dac_pos_ref <= trial;
			dac_neg_ref <= ~trial & active;
		end else begin
			dac_pos_ref <= '0;
			dac_neg_ref <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Busy, done and output code

	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy <= 1'h0;
			conv_done <= 1'h0;
		end else begin
			busy <= (state_nxt != ST_ACQ) && (state_nxt != ST_DONE);
			conv_done <= (state_nxt == ST_DONE);
		end
	end

	// Offset binary search result; flipping the MSB gives two's complement.
	// All ones trial lands on the positive end code, all zeros on the negative.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_code <= CODE_ZERO;
		end else if (state_nxt == ST_DONE) begin
			result_code <= {~trial[CODE_W-1], trial[CODE_W-2:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overvoltage flag

	logic reg_read_done;

	// Set wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			overvoltage_flag_n <= OV_FLAG_RESET;
		end else if (clamp_now) begin
			overvoltage_flag_n <= 1'h0;
		end else if (reg_read_done) begin
			overvoltage_flag_n <= 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial readout

	logic [FRAME_W-1:0] shift_r;
	logic [7:0] bit_cnt_r;
	logic frame_reg_r;
	logic in_frame_r;
	sarc_frame_s data_frame;
	logic [REG_FRAME_BITS-1:0] cfg_word;

	always_comb begin
		data_frame.code = result_code;
		data_frame.ov_n = overvoltage_flag_n;
		data_frame.span = sw_r.span_sel;
		cfg_word = '0;
		cfg_word[CFG_OV_BIT] = overvoltage_flag_n;
		cfg_word[CFG_SPAN_BIT] = span_comp_en;
	end

	assign reg_read_done = cs_rise && in_frame_r && frame_reg_r &&
		(bit_cnt_r >= 8'(REG_FRAME_BITS));

	// Snapshot at frame start keeps a read coherent against a finishing conversion
	always_ff @(posedge core_clk) begin
		if (rst) begin
			shift_r <= '0;
			bit_cnt_r <= 8'h00;
			frame_reg_r <= 1'h0;
			in_frame_r <= 1'h0;
		end else if (cs_fall) begin
			in_frame_r <= 1'h1;
			bit_cnt_r <= 8'h00;
			frame_reg_r <= sync_r[SI_REG_SEL];
			if (sync_r[SI_REG_SEL]) begin
				shift_r <= {cfg_word, {STATUS_W{1'h0}}};
			end else begin
				shift_r <= data_frame;
			end
		end else if (cs_rise) begin
			in_frame_r <= 1'h0;
		end else if (in_frame_r) begin
			if (sck_fall) begin
				shift_r <= {shift_r[FRAME_W-2:0], 1'h0};
			end
			if (sck_rise && bit_cnt_r != 8'hff) begin
				bit_cnt_r <= bit_cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			spi_sdo <= 1'h0;
		end else begin
			spi_sdo <= in_frame_r & shift_r[FRAME_W-1];
		end
	end

endmodule : sarc_conv_ctrl

// *** verilog/sarc_pkg.sv ***
/*
 * Shared constants, state codes and carriers of the SAR conversion control.
 * Assumes a single 100 MHz core clock and a synchronous active-high reset.
 */
package sarc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths and timing
	localparam int CODE_W = 16;
	localparam int STATUS_W = 2;
	localparam int FRAME_W = CODE_W + STATUS_W;
	localparam int REG_FRAME_BITS = 16;
	localparam int CORE_CLK_MHZ = 100;
	localparam int CONV_CLK_MHZ = 25;
	localparam int CONV_DIV = CORE_CLK_MHZ / CONV_CLK_MHZ;
	localparam int SYNC_IN_W = 7;

	////////////////////////////////////////////////////////////////////////
	// Codes and reset values
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_POS_MAX = 16'h7fff;
	localparam logic [15:0] CODE_NEG_MAX = 16'h8000;
	localparam logic OV_FLAG_RESET = 1'h1;
	localparam int SPAN_NUM = 4;
	localparam int SPAN_DEN = 5;

	////////////////////////////////////////////////////////////////////////
	// Positions in the configuration word and the sync vector
	localparam int CFG_OV_BIT = 4;
	localparam int CFG_SPAN_BIT = 3;
	localparam int SI_CNV = 0;
	localparam int SI_COMP = 1;
	localparam int SI_CLAMP_P = 2;
	localparam int SI_CLAMP_N = 3;
	localparam int SI_CS_N = 4;
	localparam int SI_SCK = 5;
	localparam int SI_REG_SEL = 6;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [4:0] {
		ST_ACQ = 5'h01,
		ST_OPEN_GND = 5'h02,
		ST_TO_GND = 5'h04,
		ST_SEARCH = 5'h08,
		ST_DONE = 5'h10
	} sarc_state_e;

	typedef struct packed {
		logic gnd_pos;
		logic gnd_neg;
		logic to_input;
		logic span_sel;
	} sarc_switch_s;

	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic ov_n;
		logic span;
	} sarc_frame_s;

endpackage : sarc_pkg

// *** verilog/sarc_sar_core.sv ***
/*
 * Successive approximation register: one-hot test bit walking from MSB to LSB.
 * Assumes load and step are one-cycle pulses on core_clk and never coincide.
 */
`timescale 1ns/1ps
module sarc_sar_core
	import sarc_pkg::*;
#(
	parameter int W = CODE_W
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic step,
	input wire logic keep,
	output logic [W-1:0] trial_r,
	output logic [W-1:0] active_r,
	output logic search_end_r
);

	logic [W-1:0] mask_r;
	logic [W-1:0] msb;

	assign msb = {1'h1, {(W-1){1'h0}}};

	////////////////////////////////////////////////////////////////////////
	// Binary search, MSB first
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trial_r <= '0;
			mask_r <= '0;
			active_r <= '0;
			search_end_r <= 1'h0;
		end else if (load) begin
			trial_r <= msb;
			mask_r <= msb;
			active_r <= msb;
			search_end_r <= 1'h0;
		end else if (step && mask_r != '0) begin
			// Drop the tested bit if the comparator says the trial overshot
			trial_r <= (keep ? trial_r : (trial_r & ~mask_r)) | (mask_r >> 1);
			mask_r <= mask_r >> 1;
			active_r <= active_r | (mask_r >> 1);
			search_end_r <= mask_r[0];
		end else begin
			search_end_r <= 1'h0;
		end
	end

endmodule : sarc_sar_core
